//--- bench/tdmsc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tdmsc_ctrl_monitor
	import tdmsc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Core port
	input wire logic [2:0] CORE_ADDR,
	input wire logic CORE_STORE,
	input wire logic CORE_LOAD,
	input wire logic [15:0] CORE_WDATA,
	input wire logic CORE_ACK,
	input wire logic [15:0] CORE_RDATA,
	// Serial line
	input wire logic TDM_SCLK,
	input wire logic TDM_FS,
	input wire logic TDM_DIN,
	input wire logic TDM_DOUT,
	input wire logic TDM_DOUT_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic st_q, ld_q, sw, lw, oe_en, se_seen, le_seen, armed, wr_st, rd_st;
	logic [2:0] a_q;
	logic [15:0] d_q;
	// The core drops its request inside the ack cycle, so keep the taken one
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q <= 1'b0;
			ld_q <= 1'b0;
			a_q <= 3'h0;
			d_q <= 16'h0;
		end else begin
			st_q <= CORE_STORE;
			ld_q <= CORE_LOAD;
			a_q <= CORE_ADDR;
			d_q <= CORE_WDATA;
		end
	end
	assign wr_st = CORE_ACK && st_q && a_q == IDX_STATUS;
	assign rd_st = CORE_ACK && ld_q && !st_q && a_q == IDX_STATUS;
	// Shadow of the status bits the properties depend on
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sw <= 1'b0;
			lw <= 1'b0;
			oe_en <= 1'b1;
			armed <= 1'b0;
		end else if (wr_st) begin
			sw <= d_q[B_STORE_WAIT];
			lw <= d_q[B_LOAD_WAIT];
			oe_en <= d_q[B_OUT_EN];
			armed <= armed | d_q[B_IN_CONT] | d_q[B_IN_SINGLE];
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			se_seen <= 1'b0;
			le_seen <= 1'b0;
		end else if (wr_st) begin
			se_seen <= se_seen & d_q[B_STORE_ERR];
			le_seen <= le_seen & d_q[B_LOAD_ERR];
		end else if (rd_st) begin
			se_seen <= CORE_RDATA[B_STORE_ERR];
			le_seen <= CORE_RDATA[B_LOAD_ERR];
		end
	end
	////////////////////////////////////////
	sequence s_take_st;
		CORE_STORE && !CORE_ACK;
	endsequence
	sequence s_take_ld;
		CORE_LOAD && !CORE_STORE && !CORE_ACK;
	endsequence
	property p_store_nowait;
		s_take_st ##0 !sw |=> CORE_ACK;
	endproperty
	a_store_nowait: assert property (p_store_nowait) else $error("store stalled");
	property p_load_nowait;
		s_take_ld ##0 !lw |-> ##1 CORE_ACK;
	endproperty
	a_load_nowait: assert property (p_load_nowait) else $error("load stalled");
	property p_single_clear;
		rd_st |-> !CORE_RDATA[B_IN_SINGLE];
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("start kept");
	property p_rst_clear;
		rd_st |-> CORE_RDATA[B_OUT_RST:B_IN_RST] == 2'b00;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset bit kept");
	property p_oe_off;
		!oe_en |-> !TDM_DOUT_OE;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drive while disabled");
	property p_serr_sticky;
		rd_st && se_seen |-> CORE_RDATA[B_STORE_ERR];
	endproperty
	a_serr_sticky: assert property (p_serr_sticky) else $error("store err lost");
	property p_lerr_sticky;
		rd_st && le_seen |-> CORE_RDATA[B_LOAD_ERR];
	endproperty
	a_lerr_sticky: assert property (p_lerr_sticky) else $error("load err lost");
	property p_idle_no_word;
		rd_st && !armed |-> !CORE_RDATA[B_LOAD_OK];
	endproperty
	a_idle_no_word: assert property (p_idle_no_word) else $error("word unarmed");
endmodule // tdmsc_ctrl_monitor
bind tdmsc_ctrl tdmsc_ctrl_monitor u_mon (.CLK(CLK), .RST(RST),
	.CORE_ADDR(CORE_ADDR), .CORE_STORE(CORE_STORE), .CORE_LOAD(CORE_LOAD),
	.CORE_WDATA(CORE_WDATA), .CORE_ACK(CORE_ACK), .CORE_RDATA(CORE_RDATA),
	.TDM_SCLK(TDM_SCLK), .TDM_FS(TDM_FS), .TDM_DIN(TDM_DIN),
	.TDM_DOUT(TDM_DOUT), .TDM_DOUT_OE(TDM_DOUT_OE));
`default_nettype wire

//--- bench/tdmsc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tdmsc_ctrl_tb;
	import tdmsc_pkg::*;
	logic clk, rst, st, ld, ack, sclk, fs, din, dout, oe;
	logic [2:0] addr;
	logic [15:0] wd, rd;
	int n_errors = 0;
	int n_compared = 0;
	tdmsc_ctrl dut (.CLK(clk), .RST(rst), .CORE_ADDR(addr), .CORE_STORE(st),
		.CORE_LOAD(ld), .CORE_WDATA(wd), .CORE_ACK(ack), .CORE_RDATA(rd),
		.TDM_SCLK(sclk), .TDM_FS(fs), .TDM_DIN(din), .TDM_DOUT(dout),
		.TDM_DOUT_OE(oe));
	tdmsc_line_model line (.clk(clk), .sclk(sclk), .fs(fs), .din(din),
		.dout(dout), .dout_oe(oe));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Request held until ack shows, dropped inside the ack cycle
	task automatic acc(input logic s, input logic [2:0] a, input logic [15:0] d,
		output logic [15:0] q, output int w);
		@(negedge clk);
		addr = a;
		wd = d;
		st = s;
		ld = ~s;
		w = 0;
		do begin
			@(negedge clk);
			w++;
		end while (ack !== 1'b1 && w < 4000);
		if (w >= 4000) begin
			n_errors++;
			$display("BAD %0t no ack", $time);
		end
		q = rd;
		st = 1'b0;
		ld = 1'b0;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		logic [15:0] q;
		int w;
		acc(1'b1, a, d, q, w);
	endtask
	task automatic chk(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] q;
		int w;
		acc(1'b0, a, 16'h0, q, w);
		cmp(q, e);
	endtask
	task automatic rst_dut;
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
	endtask
	// Captured line bits, first one out lands in the highest used position
	function automatic logic [15:0] bits(input int s, input int n, input bit o);
		logic [15:0] r;
		r = 16'h0;
		for (int i = 0; i < n; i++)
			r = {r[14:0], o ? line.cap_oe[s + i] : line.cap[s + i]};
		return r;
	endfunction
	initial begin
		#500000;
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		logic [15:0] q;
		int ws, wl;
		rst = 1'b1;
		st = 1'b0;
		ld = 1'b0;
		addr = 3'h0;
		wd = 16'h0;
		rst_dut();
		chk(IDX_STATUS, STATUS_RST);
		chk(IDX_FORMAT, FORMAT_RST);
		chk(IDX_TXF_LO, TXF_RST);
		wr(3'h6, 16'h1234);
		chk(3'h5, 16'h0000);
		// Slot count 1 both ways, 16-bit MSB first, continuous input
		wr(IDX_FORMAT, 16'h0101);
		wr(IDX_TXF_LO, 16'hfffe);
		wr(IDX_STATUS, 16'h02c0);
		wr(IDX_DATA, 16'ha5c3);
		line.frame(34, 16'h3c96);
		cmp(bits(0, 16, 0), 16'ha5c3);
		cmp(bits(0, 16, 1), 16'hffff);
		cmp(bits(16, 16, 1), 16'h0000);
		chk(IDX_STATUS, 16'h02c3);
		chk(IDX_DATA, 16'h3c96);
		chk(IDX_STATUS, 16'h02c2);
		chk(IDX_DATA, 16'h3c96);
		chk(IDX_STATUS, 16'h02c6);
		chk(IDX_STATUS, 16'h02c6); // sticky
		wr(IDX_STATUS, 16'h02c0);
		chk(IDX_STATUS, 16'h02c2);
		wr(IDX_DATA, 16'h1111);
		wr(IDX_DATA, 16'h2222);
		chk(IDX_STATUS, 16'h02c8);
		chk(IDX_STATUS, 16'h02c8); // sticky
		wr(IDX_STATUS, 16'h0020);
		repeat (3) @(negedge clk);
		wr(IDX_STATUS, 16'h0010); // input side
		repeat (3) @(negedge clk); // input side
		chk(IDX_STATUS, 16'h0002);
		line.frame(17, 16'hffff);
		cmp(bits(0, 16, 1), 16'h0000);
		// Byte words, LSB first both ways
		rst_dut();
		wr(IDX_FORMAT, 16'h0101);
		wr(IDX_TXF_LO, 16'hfffe);
		wr(IDX_STATUS, 16'hf2c0);
		wr(IDX_DATA, 16'h00b1);
		line.frame(9, 16'h6d00);
		cmp(bits(0, 8, 0), 16'h008d);
		cmp(bits(8, 1, 1), 16'h0000);
		chk(IDX_DATA, 16'h00b6);
		// Wait states: a stalled access finishes once its flag rises
		rst_dut();
		wr(IDX_FORMAT, 16'h0101);
		wr(IDX_TXF_LO, 16'hfffe);
		wr(IDX_STATUS, 16'h0ec0);
		wr(IDX_DATA, 16'h1234);
		fork
			acc(1'b1, IDX_DATA, 16'h5678, q, ws);
			line.frame(17, 16'h9abc);
		join
		cmp({15'h0, ws > 4}, 16'h0001);
		chk(IDX_DATA, 16'h9abc);
		fork
			acc(1'b0, IDX_DATA, 16'h0, q, wl);
			line.frame(17, 16'h0f1e);
		join
		cmp({15'h0, wl > 4}, 16'h0001);
		cmp(q, 16'h0f1e);
		cmp(bits(0, 16, 0), 16'h5678);
		chk(IDX_STATUS, 16'h0ec2);
		// Single input takes one word only
		rst_dut();
		wr(IDX_FORMAT, 16'h0101);
		wr(IDX_STATUS, 16'h01c0);
		chk(IDX_STATUS, 16'h00c2);
		line.frame(17, 16'h4321);
		chk(IDX_DATA, 16'h4321);
		line.frame(17, 16'h1357);
		chk(IDX_STATUS, 16'h00c2);
		// Window code 1: tx window slots 16 and 17 with slot 16 flagged off, so tx drives slot 17 only, rx slot 16 only
		rst_dut();
		wr(IDX_FORMAT, 16'h2221);
		wr(IDX_TXF_LO, 16'hfffd);
		wr(IDX_STATUS, 16'h32c0);
		wr(IDX_DATA, 16'h005a);
		line.frame(152, 16'h0000);
		for (int s = 0; s < 17; s++)
			cmp(bits(s * 8, 8, 1), 16'h0000);
		cmp(bits(136, 8, 0), 16'h005a);
		cmp(bits(136, 8, 1), 16'h00ff);
		cmp(bits(144, 8, 1), 16'h0000);
		chk(IDX_DATA, 16'h00aa);
		end_sim();
	end
endmodule // tdmsc_ctrl_tb
`default_nettype wire

//--- bench/tdmsc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far end of the line; its bit clock stands still between frames
module tdmsc_line_model (
	// Clock
	input wire logic clk,
	// Line
	output logic sclk,
	output logic fs,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	logic cap [0:255];
	logic cap_oe [0:255];
	initial begin
		sclk = 1'b0;
		fs = 1'b0;
		din = 1'b0;
	end
	// Bit i goes out as w[15-i]; past bit 15 the line stays driven and toggles
	task automatic frame(input int n, input logic [15:0] w);
		for (int i = 0; i < n; i++) begin
			fs = (i == 0);
			repeat (8) @(negedge clk);
			sclk = 1'b1;
			repeat (8) @(negedge clk);
			sclk = 1'b0;
			cap[i] = dout;
			cap_oe[i] = dout_oe;
			din = (i < 16) ? w[15 - i] : ~din;
		end
		din = ~din;
	endtask
endmodule // tdmsc_line_model
`default_nettype wire

//--- design/tdmsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tdmsc_ctrl
	import tdmsc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Core load/store port
	input wire logic [2:0] CORE_ADDR,
	input wire logic CORE_STORE,
	input wire logic CORE_LOAD,
	input wire logic [15:0] CORE_WDATA,
	output logic CORE_ACK,
	output logic [15:0] CORE_RDATA,
	// TDM serial line
	input wire logic TDM_SCLK,
	input wire logic TDM_FS,
	input wire logic TDM_DIN,
	output logic TDM_DOUT,
	output logic TDM_DOUT_OE
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [3:0] last_bit(input logic byte_words);
		last_bit = byte_words ? LAST_BIT8 : LAST_BIT16;
	endfunction

	function automatic logic [3:0] bit_index(input logic [3:0] cnt,
			input logic lsb_first, input logic byte_words);
		bit_index = lsb_first ? cnt : (last_bit(byte_words) - cnt);
	endfunction

	function automatic logic slot_in(input logic [7:0] slot,
			input logic [2:0] pos, input logic [4:0] count);
		logic [8:0] base;
		logic [8:0] rel;
		logic [8:0] limit;
		base = {2'b00, pos, 4'h0};
		rel = {1'b0, slot} - base;
		limit = (count == 5'h00) ? SLOTS_PER_WIN : {4'h0, count};
		slot_in = ({1'b0, slot} >= base) && (rel < limit);
	endfunction

	function automatic logic [7:0] slot_step(input logic [7:0] slot);
		slot_step = (slot == SLOT_MAX) ? slot : slot + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] filt;
	logic prev_sclk;
	logic sclk_rise;
	logic fs_in;
	logic din_in;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
			filt <= 3'h0;
			prev_sclk <= 1'b0;
		end else begin
			sync1 <= {TDM_SCLK, TDM_FS, TDM_DIN};
			sync2 <= sync1;
			sync3 <= sync2;
			// A level is taken only once two stages agree
			filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
			prev_sclk <= filt[2];
		end
	end

	assign sclk_rise = filt[2] & ~prev_sclk;
	assign fs_in = filt[1];
	assign din_in = filt[0];

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic out_lsb_first, in_lsb_first, out_byte_words, in_byte_words;
	logic store_wait_en, load_wait_en, in_continuous, in_single_start;
	logic out_path_en, in_path_en, out_soft_reset, in_soft_reset;
	logic store_err, load_err, store_ok, load_ok;
	logic [15:0] tdm_frame_format;
	logic [15:0] tx_slot_flags_lo;
	logic [15:0] tx_slot_flags_hi;
	logic [15:0] tx_hold;
	logic [15:0] data_holding_reg;
	logic [2:0] tx_window_pos;
	logic [4:0] tx_slot_count;
	logic [2:0] rx_window_pos;
	logic [4:0] rx_slot_count;
	logic [31:0] tx_flags;
	logic [15:0] status_word;

	assign tx_window_pos = tdm_frame_format[F_TX_POS +: 3];
	assign tx_slot_count = tdm_frame_format[F_TX_CNT +: 5];
	assign rx_window_pos = tdm_frame_format[F_RX_POS +: 3];
	assign rx_slot_count = tdm_frame_format[F_RX_CNT +: 5];
	assign tx_flags = {tx_slot_flags_hi, tx_slot_flags_lo};
	assign status_word = {out_lsb_first, in_lsb_first, out_byte_words,
		in_byte_words, store_wait_en, load_wait_en, in_continuous,
		in_single_start, out_path_en, in_path_en, out_soft_reset,
		in_soft_reset, store_err, load_err, store_ok, load_ok};

	////////////////////////////////////////////////////////////////////////
	// Core access

	logic access, is_data, stall, do_store, do_load;
	logic st_status, st_data, ld_data;
	logic tx_load, rx_pop;

	// The core holds its request until it sees CORE_ACK
	assign access = (CORE_STORE | CORE_LOAD) & ~CORE_ACK;
	assign is_data = CORE_ADDR == IDX_DATA;
	assign stall = is_data & (CORE_STORE ?
		(store_wait_en & ~store_ok) :
		(load_wait_en & ~load_ok));
	assign do_store = access & CORE_STORE & ~stall;
	assign do_load = access & ~CORE_STORE & CORE_LOAD & ~stall;
	assign st_status = do_store & (CORE_ADDR == IDX_STATUS);
	assign st_data = do_store & is_data;
	assign ld_data = do_load & is_data;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CORE_ACK <= 1'b0;
			CORE_RDATA <= 16'h0000;
		end else begin
			CORE_ACK <= do_store | do_load;
			if (do_load) begin
				unique case (CORE_ADDR)
					IDX_STATUS: CORE_RDATA <= status_word;
					IDX_FORMAT: CORE_RDATA <= tdm_frame_format;
					IDX_DATA: CORE_RDATA <= data_holding_reg;
					IDX_TXF_LO: CORE_RDATA <= tx_slot_flags_lo;
					IDX_TXF_HI: CORE_RDATA <= tx_slot_flags_hi;
					default: CORE_RDATA <= 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			{out_lsb_first, in_lsb_first, out_byte_words, in_byte_words,
				store_wait_en, load_wait_en, in_continuous, out_path_en,
				in_path_en} <= {STATUS_RST[15:9], STATUS_RST[7:6]};
		end else if (st_status) begin
			out_lsb_first <= CORE_WDATA[B_OUT_LSB];
			in_lsb_first <= CORE_WDATA[B_IN_LSB];
			out_byte_words <= CORE_WDATA[B_OUT_BYTE];
			in_byte_words <= CORE_WDATA[B_IN_BYTE];
			store_wait_en <= CORE_WDATA[B_STORE_WAIT];
			load_wait_en <= CORE_WDATA[B_LOAD_WAIT];
			in_continuous <= CORE_WDATA[B_IN_CONT];
			out_path_en <= CORE_WDATA[B_OUT_EN];
			in_path_en <= CORE_WDATA[B_IN_EN];
		end
	end

	// Self-clearing bits are high for one cycle only, the ack cycle, so loads read them as 0
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			in_single_start <= STATUS_RST[B_IN_SINGLE];
			out_soft_reset <= STATUS_RST[B_OUT_RST];
			in_soft_reset <= STATUS_RST[B_IN_RST];
		end else begin
			in_single_start <= st_status & CORE_WDATA[B_IN_SINGLE];
			out_soft_reset <= st_status & CORE_WDATA[B_OUT_RST];
			in_soft_reset <= st_status & CORE_WDATA[B_IN_RST];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tdm_frame_format <= FORMAT_RST;
			tx_slot_flags_lo <= TXF_RST;
			tx_slot_flags_hi <= TXF_RST;
		end else if (do_store) begin
			if (CORE_ADDR == IDX_FORMAT) begin
				tdm_frame_format <= CORE_WDATA;
			end
			if (CORE_ADDR == IDX_TXF_LO) begin
				tx_slot_flags_lo <= CORE_WDATA;
			end
			if (CORE_ADDR == IDX_TXF_HI) begin
				tx_slot_flags_hi <= CORE_WDATA;
			end
		end
	end

	// A store into a full holding register is dropped, not overwritten
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_hold <= 16'h0000;
		end else if (st_data && store_ok) begin
			tx_hold <= CORE_WDATA;
		end
	end

	// Error flags: a fresh error wins over a clearing write
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			store_err <= STATUS_RST[B_STORE_ERR];
			load_err <= STATUS_RST[B_LOAD_ERR];
		end else begin
			if (st_data && !store_ok) begin
				store_err <= 1'b1;
			end else if (out_soft_reset) begin
				store_err <= 1'b0;
			end else if (st_status && !CORE_WDATA[B_STORE_ERR]) begin
				store_err <= 1'b0;
			end
			if (ld_data && !load_ok) begin
				load_err <= 1'b1;
			end else if (in_soft_reset) begin
				load_err <= 1'b0;
			end else if (st_status && !CORE_WDATA[B_LOAD_ERR]) begin
				load_err <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			store_ok <= STATUS_RST[B_STORE_OK];
		end else if (out_soft_reset) begin
			store_ok <= 1'b1;
		end else if (tx_load) begin
			store_ok <= 1'b1;
		end else if (st_data) begin
			store_ok <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			load_ok <= STATUS_RST[B_LOAD_OK];
		end else if (in_soft_reset) begin
			load_ok <= 1'b0;
		end else if (rx_pop) begin
			load_ok <= 1'b1;
		end else if (ld_data) begin
			load_ok <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit side

	logic [3:0] tx_bit, next_tx_bit;
	logic [7:0] tx_slot, next_tx_slot;
	logic [4:0] tx_rel;
	logic [15:0] tx_shreg, tx_word;
	logic tx_on, tx_slot_ok;

	always_comb begin
		if (fs_in) begin
			next_tx_bit = 4'h0;
			next_tx_slot = 8'h00;
		end else if (tx_bit == last_bit(out_byte_words)) begin
			next_tx_bit = 4'h0;
			next_tx_slot = slot_step(tx_slot);
		end else begin
			next_tx_bit = tx_bit + 4'h1;
			next_tx_slot = tx_slot;
		end
	end

	assign tx_rel = next_tx_slot[4:0] - {tx_window_pos[0], 4'h0};
	assign tx_slot_ok = out_path_en &
		slot_in(next_tx_slot, tx_window_pos, tx_slot_count) &
		~tx_flags[tx_rel];
	assign tx_load = sclk_rise & (next_tx_bit == 4'h0) & tx_slot_ok &
		~store_ok & ~out_soft_reset;
	assign tx_word = tx_load ? tx_hold : tx_shreg;

	// An empty holding register leaves the slot undriven
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_bit <= 4'h0;
			tx_slot <= 8'h00;
			tx_shreg <= 16'h0000;
			tx_on <= 1'b0;
			TDM_DOUT <= 1'b0;
			TDM_DOUT_OE <= 1'b0;
		end else if (out_soft_reset) begin
			tx_bit <= 4'h0;
			tx_slot <= 8'h00;
			tx_on <= 1'b0;
			TDM_DOUT <= 1'b0;
			TDM_DOUT_OE <= 1'b0;
		end else if (sclk_rise) begin
			tx_bit <= next_tx_bit;
			tx_slot <= next_tx_slot;
			tx_shreg <= tx_word;
			if (next_tx_bit == 4'h0) begin
				tx_on <= tx_load;
			end
			TDM_DOUT <= tx_word[bit_index(next_tx_bit, out_lsb_first,
				out_byte_words)];
			TDM_DOUT_OE <= out_path_en &
				((next_tx_bit == 4'h0) ? tx_load : tx_on);
		end else if (!out_path_en) begin
			TDM_DOUT_OE <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive side

	logic [3:0] rx_bit;
	logic [7:0] rx_slot;
	logic [15:0] rx_shreg, rx_word;
	logic rx_on, rx_take, rx_armed, single_pending;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
	logic [15:0] fifo_in_data, fifo_out_data;

	assign rx_armed = in_path_en & (in_continuous | single_pending);
	// A word starts only with room in the FIFO, so slots that begin while it is full are skipped
	assign rx_take = (rx_bit == 4'h0) ?
		(slot_in(rx_slot, rx_window_pos, rx_slot_count) &
		rx_armed & fifo_in_ready) : rx_on;

	always_comb begin
		rx_word = rx_shreg;
		rx_word[bit_index(rx_bit, in_lsb_first, in_byte_words)] = din_in;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			single_pending <= 1'b0;
		end else if (in_soft_reset) begin
			single_pending <= 1'b0;
		end else if (in_single_start) begin
			single_pending <= 1'b1;
		end else if (sclk_rise && !fs_in && rx_bit == 4'h0 && rx_take) begin
			single_pending <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_bit <= 4'h0;
			rx_slot <= 8'h00;
			rx_shreg <= 16'h0000;
			rx_on <= 1'b0;
			fifo_in_valid <= 1'b0;
			fifo_in_data <= 16'h0000;
		end else if (in_soft_reset) begin
			rx_bit <= 4'h0;
			rx_slot <= 8'h00;
			rx_on <= 1'b0;
			fifo_in_valid <= 1'b0;
		end else begin
			fifo_in_valid <= 1'b0;
			if (sclk_rise && fs_in) begin
				rx_bit <= 4'h0;
				rx_slot <= 8'h00;
				rx_on <= 1'b0;
			end else if (sclk_rise) begin
				rx_on <= rx_take;
				if (rx_take) begin
					rx_shreg <= rx_word;
				end
				if (rx_bit == last_bit(in_byte_words)) begin
					rx_bit <= 4'h0;
					rx_slot <= slot_step(rx_slot);
					rx_on <= 1'b0;
					fifo_in_valid <= rx_take;
					fifo_in_data <= rx_word;
				end else begin
					rx_bit <= rx_bit + 4'h1;
				end
			end
		end
	end

	assign rx_pop = fifo_out_valid & ~load_ok & ~in_soft_reset;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			data_holding_reg <= 16'h0000;
		end else if (rx_pop) begin
			data_holding_reg <= fifo_out_data;
		end
	end

	tdmsc_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(CLK),
		.rst(RST),
		.flush(in_soft_reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(rx_pop),
		.out_data(fifo_out_data)
	);

endmodule // tdmsc_ctrl
`default_nettype wire

//--- design/tdmsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tdmsc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] cnt;
	logic push;
	logic pull;

	// Depth must be a power of two so the pointers wrap by themselves
	assign in_ready = cnt < FULL;
	assign push = in_valid & in_ready;
	assign pull = (cnt != '0) & (~out_valid | out_ready);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr <= '0;
			rptr <= '0;
			cnt <= '0;
		end else if (flush) begin
			wptr <= '0;
			rptr <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wptr <= wptr + 1'b1;
			end
			if (pull) begin
				rptr <= rptr + 1'b1;
			end
			if (push && !pull) begin
				cnt <= cnt + 1'b1;
			end else if (pull && !push) begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	// Output stage is a register, so read data comes from the array one cycle after a pull
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (flush) begin
			out_valid <= 1'b0;
		end else begin
			if (pull) begin
				out_data <= mem[rptr];
			end
			out_valid <= pull | (out_valid & ~out_ready);
		end
	end
endmodule // tdmsc_fifo
`default_nettype wire

//--- design/tdmsc_pkg.sv
`default_nettype none
package tdmsc_pkg;

	// Register index on CORE_ADDR
	localparam logic [2:0] IDX_STATUS = 3'h0;
	localparam logic [2:0] IDX_FORMAT = 3'h1;
	localparam logic [2:0] IDX_DATA = 3'h2;
	localparam logic [2:0] IDX_TXF_LO = 3'h3;
	localparam logic [2:0] IDX_TXF_HI = 3'h4;

	// serial_control_status field positions
	localparam int B_OUT_LSB = 15;
	localparam int B_IN_LSB = 14;
	localparam int B_OUT_BYTE = 13;
	localparam int B_IN_BYTE = 12;
	localparam int B_STORE_WAIT = 11;
	localparam int B_LOAD_WAIT = 10;
	localparam int B_IN_CONT = 9;
	localparam int B_IN_SINGLE = 8;
	localparam int B_OUT_EN = 7;
	localparam int B_IN_EN = 6;
	localparam int B_OUT_RST = 5;
	localparam int B_IN_RST = 4;
	localparam int B_STORE_ERR = 3;
	localparam int B_LOAD_ERR = 2;
	localparam int B_STORE_OK = 1;
	localparam int B_LOAD_OK = 0;

	// tdm_frame_format field positions (low bit of each field)
	localparam int F_TX_POS = 13;
	localparam int F_TX_CNT = 8;
	localparam int F_RX_POS = 5;
	localparam int F_RX_CNT = 0;

	// Reset values
	localparam logic [15:0] STATUS_RST = 16'h00c2;
	localparam logic [15:0] FORMAT_RST = 16'h0000;
	localparam logic [15:0] TXF_RST = 16'hffff;

	// Sizes
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] LAST_BIT16 = 4'hf;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [8:0] SLOTS_PER_WIN = 9'h020;
	localparam logic [7:0] SLOT_MAX = 8'hff;

endpackage
`default_nettype wire
